// ===== src/tuner_pll_control.sv
// Tuner PLL control block: two-wire slave and 3-wire shift port.
`timescale 1ns/1ps
`default_nettype none
`include "tuner_pll_map.svh"

module tuner_pll_control
   import tuner_pll_pkg::*;
#(
   parameter bit BAND_FIRST = 1'b1
)(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Bus pins.
   input  wire logic       bus_clock_pin,
   input  wire logic       bus_data_pin,
   output var  logic       sda_out,
   output var  logic       sda_oe,
   input  wire logic       address_strap_enable_pin,
   input  wire logic [1:0] strap_zone,
   input  wire logic       bus_select_pin_gnd,
   input  wire logic       bus_select_pin_vcc,
   // Status inputs.
   input  wire logic       lock_detect,
   input  wire logic [2:0] level_zone,
   // Synthesiser controls.
   output var  logic [14:0] division_ratio,
   output var  logic [7:0]  refdiv_ratio,
   output var  logic        pump_current_select,
   output var  logic        pump_disable,
   output var  logic        varicap_output_disable,
   output var  logic        band_output_1,
   output var  logic        band_output_2,
   output var  logic        band_output_3,
   output var  logic        band_output_4
);

   // ---------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------

   pins_t raw;   // Pins as they arrive.
   pins_t lv;    // Filtered levels.
   pins_t rs;    // Rising-edge pulses.
   pins_t fl;    // Falling-edge pulses.

   // All pins but strap_zone share one synchroniser, so edges keep their order.
   assign raw = '{scl: bus_clock_pin, sda: bus_data_pin,
                  ce: address_strap_enable_pin,
                  bus_gnd: bus_select_pin_gnd,
                  bus_vcc: bus_select_pin_vcc,
                  lock: lock_detect, level: level_zone};

   pin_sync #(.WIDTH(9)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (raw),
      .level (lv),
      .rise  (rs),
      .fall  (fl)
   );

   // ---------------------------------------------------------------
   // Shared decoding
   // ---------------------------------------------------------------

   // Unpack a control byte into its fields.
   function automatic ctrl_t ctl_of(input logic [7:0] b);
      ctl_of = '{cp: b[`CTL_CP], cd: b[`CTL_CD], r1: b[`CTL_R1],
                 r0: b[`CTL_R0], os: b[`CTL_OS]};
   endfunction

   logic i2c_mode;   // Two-wire bus selected.
   logic tw_mode;    // 3-wire bus selected.

   // Grounded select pin means two-wire; open or supply means 3-wire.
   assign i2c_mode = lv.bus_gnd;
   assign tw_mode  = ~lv.bus_gnd;

   // ---------------------------------------------------------------
   // Strap capture
   // ---------------------------------------------------------------

   logic [1:0] strap_q;       // Captured address strap bits.
   logic       strap_took_q;  // Strap already taken.

   // The comparator zone index is already the strap code, so it is
   // caught once after reset and held; the pin is static by then.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_q      <= 2'h0;
         strap_took_q <= 1'h0;
      end else if (!strap_took_q) begin
         strap_q      <= strap_zone;
         strap_took_q <= 1'h1;
      end
   end

   // ---------------------------------------------------------------
   // Two-wire conditions and status byte
   // ---------------------------------------------------------------

   logic       start;        // Start or repeated start.
   logic       stop;         // Stop condition.
   logic       scl_r;        // Clock rise in two-wire mode.
   logic       scl_f;        // Clock fall in two-wire mode.
   logic [2:0] level_code;   // Clamped converter code.
   logic [7:0] status_byte;  // Byte returned on reads.

   assign start = i2c_mode & lv.scl & fl.sda;
   assign stop  = i2c_mode & lv.scl & rs.sda;
   assign scl_r = i2c_mode & rs.scl;
   assign scl_f = i2c_mode & fl.scl;

   // Zones 0..4 map straight to codes 000..100.
   assign level_code = (lv.level > `LEVEL_CODE_MAX) ?
                       `LEVEL_CODE_MAX : lv.level;
   // Bit 7 is undefined and sent as 0.
   assign status_byte = {1'h0, lv.lock, `STATUS_ONES,
                         level_code};

   // ---------------------------------------------------------------
   // Two-wire slave state machine
   // ---------------------------------------------------------------

   i2c_state_t st_q, st_d;   // Slave state.
   logic [3:0] bit_q, bit_d; // Bits in current byte.
   logic [7:0] sh_q;         // Receive shifter.
   logic [7:0] tx_q, tx_d;   // Transmit shifter.
   logic       rw_q, rw_d;   // Read transfer.
   logic       ack_q, ack_d; // Master acknowledged our byte.
   logic       oe_q, oe_d;   // Data pin pulled low.
   logic       byte_full;    // Eight bits received.
   logic       addr_hit;     // Address matches with straps.

   assign byte_full = (bit_q == `BYTE_FULL);
   assign addr_hit  = (sh_q[7:3] == `ADDR_FIXED) &&
                      (sh_q[2:1] == strap_q);

   // Next state. Bus conditions override any byte in flight.
   always_comb begin
      st_d  = st_q;
      bit_d = bit_q;
      tx_d  = tx_q;
      rw_d  = rw_q;
      ack_d = ack_q;
      oe_d  = oe_q;
      if (!i2c_mode || stop) begin
         st_d = I2C_IDLE;
         oe_d = 1'h0;
      end else if (start) begin
         // A start without a stop still opens a new transfer.
         st_d  = I2C_ADDR;
         bit_d = 4'h0;
         oe_d  = 1'h0;
      end else begin
         unique case (st_q)
            I2C_IDLE: begin
               st_d = I2C_IDLE;
            end
            I2C_ADDR: begin
               if (scl_r) begin
                  bit_d = bit_q + 4'h1;
               end else if (scl_f && byte_full) begin
                  if (addr_hit) begin
                     st_d = I2C_ACK_ADDR;
                     oe_d = 1'h1;
                     rw_d = sh_q[0];
                  end else begin
                     // Not ours: stay silent until the next start.
                     st_d = I2C_IDLE;
                  end
               end
            end
            I2C_ACK_ADDR: begin
               if (scl_f) begin
                  bit_d = 4'h0;
                  if (rw_q) begin
                     // Act as transmitter from the next clock low.
                     st_d = I2C_TX;
                     tx_d = status_byte;
                     oe_d = ~status_byte[7];
                  end else begin
                     st_d = I2C_RX;
                     oe_d = 1'h0;
                  end
               end
            end
            I2C_RX: begin
               if (scl_r) begin
                  bit_d = bit_q + 4'h1;
               end else if (scl_f && byte_full) begin
                  st_d = I2C_ACK_RX;
                  oe_d = 1'h1;
               end
            end
            I2C_ACK_RX: begin
               if (scl_f) begin
                  st_d  = I2C_RX;
                  bit_d = 4'h0;
                  oe_d  = 1'h0;
               end
            end
            I2C_TX: begin
               if (scl_f) begin
                  if (bit_q == `BYTE_LAST_BIT) begin
                     // Release the line for the master's answer.
                     st_d = I2C_ACK_TX;
                     oe_d = 1'h0;
                  end else begin
                     bit_d = bit_q + 4'h1;
                     tx_d  = {tx_q[6:0], 1'h0};
                     oe_d  = ~tx_q[6];
                  end
               end
            end
            I2C_ACK_TX: begin
               if (scl_r) begin
                  ack_d = ~lv.sda;
               end else if (scl_f) begin
                  if (ack_q) begin
                     // Master wants more: repeat the status byte.
                     st_d  = I2C_TX;
                     bit_d = 4'h0;
                     tx_d  = status_byte;
                     oe_d  = ~status_byte[7];
                  end else begin
                     st_d = I2C_IDLE;
                  end
               end
            end
            default: begin
               st_d = I2C_IDLE;
            end
         endcase
      end
   end

   // State registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q  <= I2C_IDLE;
         bit_q <= 4'h0;
         tx_q  <= 8'h00;
         rw_q  <= 1'h0;
         ack_q <= 1'h0;
         oe_q  <= 1'h0;
      end else begin
         st_q  <= st_d;
         bit_q <= bit_d;
         tx_q  <= tx_d;
         rw_q  <= rw_d;
         ack_q <= ack_d;
         oe_q  <= oe_d;
      end
   end

   // Receive shifter samples data on each clock rise in the address and receive states, MSB first.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_q <= 8'h00;
      end else if (scl_r && (st_q == I2C_ADDR || st_q == I2C_RX)) begin
         sh_q <= {sh_q[6:0], lv.sda};
      end
   end

   // ---------------------------------------------------------------
   // Two-wire byte grouping
   // ---------------------------------------------------------------

   logic       byte_done;   // A write data byte completed.
   logic       pair_done;   // Second byte of a group completed.
   logic [7:0] pend_q;      // First byte of the open group.
   logic       pend_v_q;    // A first byte is waiting.
   logic       i2c_freq_we; // Commit both divider bytes.
   logic       i2c_ctl_we;  // Commit control and band bytes.
   freq_t      i2c_freq;    // Divider word from the pair.

   assign byte_done = (st_q == I2C_RX) & scl_f & byte_full & ~start
                      & ~stop;
   // A group goes to the latches only when both bytes are in.
   assign pair_done   = byte_done & pend_v_q;
   assign i2c_freq_we = pair_done & ~pend_q[7];
   assign i2c_ctl_we  = pair_done & pend_q[7];
   // M9..M3 under a zero top bit, then M2..M0 and S4..S0.
   assign i2c_freq = {pend_q[6:0], sh_q};

   // A start drops a half-received group, so old values stay.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q   <= 8'h00;
         pend_v_q <= 1'h0;
      end else if (start) begin
         pend_v_q <= 1'h0;
      end else if (byte_done) begin
         pend_v_q <= ~pend_v_q;
         pend_q   <= pend_v_q ? pend_q : sh_q;
      end
   end

   // ---------------------------------------------------------------
   // 3-wire shift port
   // ---------------------------------------------------------------

   logic [4:0]  cnt_q;      // Clocks seen while enable is high.
   logic [26:0] wsh_q;      // Frame shifter.
   logic        tw_clk;     // Accepted data clock.
   logic        n18;        // 18-bit frame.
   logic        n19;        // 19-bit frame.
   logic        n27;        // 27 or more clocks.
   logic        w3_we;      // Latch a good frame.
   logic [3:0]  band_f;     // Band field, band first.
   logic [3:0]  band_l;     // Band field, band last.
   freq_t       freq_f;     // Divider field, band first.
   freq_t       freq_l;     // Divider field, band last.
   logic [3:0]  w3_band;    // Selected band field.
   freq_t       w3_freq;    // Selected divider field.
   ctrl_t       w3_short;   // Control for 18 or 19 bits.
   ctrl_t       w3_ctrl;    // Control to latch.
   ctrl_t       ctrl_q;     // Pump and reference control.
   ctrl_t       ctrl_d;     // Next pump and reference control.

   // Counting stops at 27, so only the first 27 bits are kept.
   assign tw_clk = tw_mode & lv.ce & rs.scl &
                   (cnt_q < `FRAME_LONG);
   assign n18 = (cnt_q == `FRAME_SHORT);
   assign n19 = (cnt_q == `FRAME_MID);
   assign n27 = (cnt_q == `FRAME_LONG);
   // Other lengths are dropped and the latches keep their data.
   assign w3_we = tw_mode & fl.ce &
                  (n18 | n19 | n27);

   // The 14-bit divider of a short frame has M9 forced low.
   assign band_f = n27 ? wsh_q[26:23] : n19 ? wsh_q[18:15]
                                            : wsh_q[17:14];
   assign freq_f = n27 ? wsh_q[22:8] : n19 ? wsh_q[14:0]
                                           : {1'h0, wsh_q[13:0]};
   assign band_l = n27 ? wsh_q[11:8] : wsh_q[3:0];
   assign freq_l = n27 ? wsh_q[26:12] : n19 ? wsh_q[18:4]
                                            : {1'h0, wsh_q[17:4]};
   assign w3_band = BAND_FIRST ? band_f : band_l;
   assign w3_freq = BAND_FIRST ? freq_f : freq_l;

   // Supply on the select pin gives 80; open gives 64 or 128.
   assign w3_short = '{cp: ctrl_q.cp, cd: ctrl_q.cd,
                       r1: ~lv.bus_vcc & n18,
                       r0: ~lv.bus_vcc,
                       os: ctrl_q.os};
   assign w3_ctrl = n27 ? ctl_of(wsh_q[7:0]) : w3_short;

   // Enable rise opens a frame; data is sampled on clock rise.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 5'h00;
         wsh_q <= 27'h0000000;
      end else if (tw_mode && rs.ce) begin
         cnt_q <= 5'h00;
         wsh_q <= 27'h0000000;
      end else if (tw_clk) begin
         cnt_q <= cnt_q + 5'h01;
         wsh_q <= {wsh_q[25:0], lv.sda};
      end
   end

   // ---------------------------------------------------------------
   // Working latches and outputs
   // ---------------------------------------------------------------

   freq_t      freq_q, freq_d;     // Divider word.
   logic [3:0] band_q, band_d;     // Band outputs 4..1.
   logic [7:0] refdiv_q, refdiv_d; // Reference divider ratio.

   // Each source writes only complete groups.
   assign freq_d = i2c_freq_we ? i2c_freq :
                   w3_we       ? w3_freq  : freq_q;
   assign ctrl_d = i2c_ctl_we  ? ctl_of(pend_q) :
                   w3_we       ? w3_ctrl  : ctrl_q;
   assign band_d = i2c_ctl_we  ? sh_q[3:0] :
                   w3_we       ? w3_band  : band_q;
   // Low select bit clear gives 80; otherwise high bit picks 64.
   assign refdiv_d = !ctrl_d.r0 ? `REFDIV_80 :
                     ctrl_d.r1  ? `REFDIV_64 :
                                  `REFDIV_128;

   // Power-up leaves the divider at zero and every band off.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         freq_q   <= `FREQ_RESET;
         band_q   <= `BAND_RESET;
         ctrl_q   <= `CTRL_RESET;
         refdiv_q <= `REFDIV_80;
      end else begin
         freq_q   <= freq_d;
         band_q   <= band_d;
         ctrl_q   <= ctrl_d;
         refdiv_q <= refdiv_d;
      end
   end

   // Open-drain data pin: the driven value is always low.
   logic sda_out_q;   // Low level for the data pin.

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_out_q <= 1'h0;
      end else begin
         sda_out_q <= 1'h0;
      end
   end

   // Outputs are taken straight from the latches above.
   assign sda_out                = sda_out_q;
   assign sda_oe                 = oe_q;
   // The packed word reads as 32 * main + swallow.
   assign division_ratio         = freq_q;
   assign refdiv_ratio           = refdiv_q;
   // Set selects the high pump current, clear the low one.
   assign pump_current_select    = ctrl_q.cp;
   assign pump_disable           = ctrl_q.cd;
   assign varicap_output_disable = ctrl_q.os;
   assign band_output_1          = band_q[0];
   assign band_output_2          = band_q[1];
   assign band_output_3          = band_q[2];
   assign band_output_4          = band_q[3];

endmodule

`default_nettype wire

// ===== src/tuner_pll_map.svh
// Offsets, field positions, reset values and counts of the PLL control block.
`ifndef TUNER_PLL_MAP_SVH
`define TUNER_PLL_MAP_SVH

// ---------------------------------------------------------------
// Two-wire address and status byte
// ---------------------------------------------------------------
`define ADDR_FIXED     5'h18
`define STATUS_ONES    3'h7
`define LEVEL_CODE_MAX 3'h4
`define BYTE_FULL      4'h8
`define BYTE_LAST_BIT  4'h7

// ---------------------------------------------------------------
// Control byte field positions
// ---------------------------------------------------------------
`define CTL_CP 6
`define CTL_CD 4
`define CTL_R1 2
`define CTL_R0 1
`define CTL_OS 0

// ---------------------------------------------------------------
// Reference divider ratios
// ---------------------------------------------------------------
`define REFDIV_128 8'h80
`define REFDIV_64  8'h40
`define REFDIV_80  8'h50

// ---------------------------------------------------------------
// 3-wire frame lengths and reset values
// ---------------------------------------------------------------
`define FRAME_SHORT 5'h12
`define FRAME_MID   5'h13
`define FRAME_LONG  5'h1B
`define FREQ_RESET  15'h0000
`define BAND_RESET  4'h0
`define CTRL_RESET  5'h00

`endif

// ===== src/tuner_pll_pkg.sv
// Types shared by the PLL control block and its bench.
package tuner_pll_pkg;

   // Divider word; {main, swallow} equals 32 * main + swallow.
   typedef struct packed {
      logic [9:0] main;
      logic [4:0] swallow;
   } freq_t;

   // Pump and reference control fields.
   typedef struct packed {
      logic cp;
      logic cd;
      logic r1;
      logic r0;
      logic os;
   } ctrl_t;

   // Pins that cross into the clk domain.
   typedef struct packed {
      logic       scl;
      logic       sda;
      logic       ce;
      logic       bus_gnd;
      logic       bus_vcc;
      logic       lock;
      logic [2:0] level;
   } pins_t;

   // Two-wire slave states.
   typedef enum logic [2:0] {
      I2C_IDLE,
      I2C_ADDR,
      I2C_ACK_ADDR,
      I2C_RX,
      I2C_ACK_RX,
      I2C_TX,
      I2C_ACK_TX
   } i2c_state_t;

endpackage

// ===== src/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int WIDTH = 9
)(
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Raw pins.
   input  wire logic [WIDTH-1:0] d,
   // Filtered level and one-cycle edge pulses.
   output var  logic [WIDTH-1:0] level,
   output var  logic [WIDTH-1:0] rise,
   output var  logic [WIDTH-1:0] fall
);

   logic [WIDTH-1:0] s1_q;   // Metastable stage, read by s2_q only.
   logic [WIDTH-1:0] s2_q;   // Second stage.
   logic [WIDTH-1:0] s3_q;   // Third stage.
   logic [WIDTH-1:0] agree;  // Second and third stages match.
   logic [WIDTH-1:0] lvl_d;  // Next filtered level.

   // A change is taken only once two settled stages agree.
   assign agree = ~(s2_q ^ s3_q);
   assign lvl_d = (agree & s2_q) | (~agree & level);

   // Shift chain and filtered outputs.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         level <= '0;
         rise  <= '0;
         fall  <= '0;
      end else begin
         s1_q  <= d;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         level <= lvl_d;
         rise  <= lvl_d & ~level;
         fall  <= ~lvl_d & level;
      end
   end

endmodule

`default_nettype wire

// ===== bench/tuner_pll_control_assertions.sv
// Pin-level checks of the PLL control block.
`timescale 1ns/1ps
`default_nettype none
module tuner_pll_control_assertions (
   input wire logic        clk, rst_n, bus_clock_pin, sda_out, sda_oe,
   input wire logic        address_strap_enable_pin, bus_select_pin_gnd,
   input wire logic [14:0] division_ratio,
   input wire logic [7:0]  refdiv_ratio,
   input wire logic        band_output_1, band_output_2,
   input wire logic        band_output_3, band_output_4
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Divider, reference ratio and band outputs in one word, so one change term covers them.
   wire logic [26:0] lat = {division_ratio, refdiv_ratio, band_output_4,
                            band_output_3, band_output_2, band_output_1};
   wire logic        gnd = bus_select_pin_gnd;
   reset_clear_a: assert property (
      $rose(rst_n) |-> lat == {15'h0000, 8'h50, 4'h0})
      else $error("outputs not at reset value");
   sda_low_a: assert property (sda_out == 1'b0)
      else $error("sda_out not low");
   ref_legal_a: assert property (
      refdiv_ratio inside {8'h50, 8'h40, 8'h80}) else $error("bad ratio");
   wire_quiet_a: assert property (!gnd [*8] |-> !sda_oe)
      else $error("data line driven in 3-wire mode");
   ack_commit_a: assert property ($changed(lat) && gnd |-> sda_oe)
      else $error("latch change outside acknowledge");
   frame_latch_a: assert property (
      $changed(lat) && !gnd |-> !address_strap_enable_pin
      && $past(address_strap_enable_pin, 8)) else $error("latch off frame");
   ack_low_a: assert property ($rose(sda_oe) |-> !bus_clock_pin)
      else $error("data driven during clock high");
   hold_high_a: assert property (
      bus_clock_pin [*8] |-> $stable(sda_oe)) else $error("data moved");
endmodule
`default_nettype wire

// ===== bench/tuner_pll_host.sv
// Behavioural bus master for both bus modes of the PLL control block.
`timescale 1ns/1ps
`default_nettype none
module tuner_pll_host (
   // Clock and the device's data pull-down.
   input  wire logic clk,
   input  wire logic sda_oe,
   // Bus pins.
   output var  logic scl,
   output var  logic ce,
   output wire logic sda_w
);
   logic m = 1'b1; // Master drive; 1 lets the pull-up win.
   assign sda_w = m & ~sda_oe;
   initial scl = 1'b1;
   initial ce = 1'b0;
   task automatic tick(int n);
      repeat (n) @(negedge clk);
   endtask
   // Data moves only while the clock is low, so no false start.
   task automatic bit_io(logic b, output logic r);
      m = b; tick(12); scl = 1'b1; tick(6); r = sda_w; tick(7); scl = 1'b0;
   endtask
   task automatic start();
      m = 1'b1; tick(12); scl = 1'b1; tick(12); m = 1'b0; tick(12);
      scl = 1'b0;
   endtask
   task automatic stop();
      m = 1'b0; tick(12); scl = 1'b1; tick(12); m = 1'b1; tick(12);
   endtask
   // Eight bits first to last, then the acknowledge bit.
   task automatic xfer(logic [7:0] b, logic a, output logic [7:0] r,
                       output logic k);
      for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
      bit_io(a, k);
   endtask
   // Clock rests low outside frames; data inverts once released.
   task automatic frame(logic [26:0] v, int n);
      logic d;
      scl = 1'b0; tick(12); ce = 1'b1;
      for (int i = n - 1; i >= 0; i--) bit_io(v[i], d);
      tick(12); ce = 1'b0; m = ~m; tick(25);
   endtask
endmodule
`default_nettype wire

// ===== bench/tuner_pll_control_tb.sv
// Self-checking bench: PLL control block against an integer model.
`timescale 1ns/1ps
`default_nettype none
module tuner_pll_control_tb;
   import tuner_pll_pkg::*;
   logic             clk, rst_n, gnd, vcc, lock, ak;
   logic [15:0]      rnd = 16'h3EDF; // Generator state, fixed seed.
   logic [1:0]       strap = 2'h3;   // Strap code, held static.
   logic [2:0]       lvl;
   logic [7:0]       rd;
   logic [26:0]      v;
   wire logic        scl, ce, sda_w, sda_out, sda_oe, cp, cd, os;
   wire logic [14:0] div;
   wire logic [7:0]  refdiv;
   wire logic [3:0]  band;
   freq_t            e_div;  // Model of the divider latch.
   ctrl_t            e_ctl;  // Model of the control latch.
   logic [3:0]       e_band; // Model of the band latch.
   int               n_mismatch = 0;
   int               compares = 0;
   int               len [6] = '{18, 19, 27, 20, 18, 19};
   tuner_pll_control i_tuner_pll_control (.clk, .rst_n, .bus_clock_pin(scl),
      .bus_data_pin(sda_w), .sda_out, .sda_oe, .address_strap_enable_pin(ce),
      .strap_zone(strap), .bus_select_pin_gnd(gnd), .bus_select_pin_vcc(vcc),
      .lock_detect(lock), .level_zone(lvl), .division_ratio(div),
      .refdiv_ratio(refdiv), .pump_current_select(cp), .pump_disable(cd),
      .varicap_output_disable(os), .band_output_1(band[0]),
      .band_output_2(band[1]), .band_output_3(band[2]),
      .band_output_4(band[3]));
   tuner_pll_host i_tuner_pll_host (.clk, .sda_oe, .scl, .ce, .sda_w);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(string nm, logic [14:0] seen, logic [14:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // All latches against the model; a clear low select bit means 80.
   task automatic outs();
      chk("div", div, e_div);
      chk("ref", refdiv, !e_ctl.r0 ? 8'h50 : e_ctl.r1 ? 8'h40 : 8'h80);
      chk("pump", {cp, cd, os}, {e_ctl.cp, e_ctl.cd, e_ctl.os});
      chk("band", band, e_band);
   endtask
   task automatic adr(logic rw);
      i_tuner_pll_host.start();
      i_tuner_pll_host.xfer({5'h18, strap, rw}, 1'b1, rd, ak);
      chk("ack", ak, 1'b0);
   endtask
   task automatic byt(logic [7:0] b);
      i_tuner_pll_host.xfer(b, 1'b1, rd, ak);
      chk("ack", ak, 1'b0);
   endtask
   task automatic print_verdict();
      if (n_mismatch == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end
   initial begin
      {rst_n, vcc, lock, lvl, e_div, e_ctl, e_band} = '0;
      gnd = 1'b1;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (12) @(negedge clk);
      outs();
      i_tuner_pll_host.start();
      i_tuner_pll_host.xfer({5'h18, ~strap, 1'b0}, 1'b1, rd, ak);
      chk("nack", ak, 1'b1);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         e_ctl = {rnd[0], rnd[1], i[1:0], rnd[2]};
         e_band = rnd[7:4];
         adr(1'b0);
         byt({1'b1, e_ctl.cp, 1'b0, e_ctl.cd, rnd[3], i[1:0], e_ctl.os});
         byt({rnd[11:8], e_band});
         i_tuner_pll_host.stop();
         outs();
      end
      adr(1'b0);
      byt(8'h7F); // Lone divider byte, cut short by a restart.
      adr(1'b0);
      e_div = rnd[14:0];
      byt({1'b0, e_div[14:8]});
      byt(e_div[7:0]);
      i_tuner_pll_host.stop();
      outs();
      for (int i = 0; i < 5; i++) begin
         {lock, lvl} = {i[0], i[2:0]};
         adr(1'b1);
         i_tuner_pll_host.xfer(8'hFF, 1'b1, rd, ak);
         i_tuner_pll_host.stop();
         chk("status", rd[6:0], {i[0], 3'h7, i[2:0]});
      end
      gnd = 1'b0;
      for (int j = 0; j < 6; j++) begin
         vcc = j[2];
         rnd = lfsr(rnd);
         v = {rnd[10:0], lfsr(rnd)};
         i_tuner_pll_host.frame(v, len[j]);
         if (len[j] == 27) begin
            {e_band, e_div} = v[26:8];
            e_ctl = {v[6], v[4], v[2:0]};
         end else if (len[j] != 20) begin
            {e_band, e_div} = len[j] == 18 ? {v[17:14], 1'b0, v[13:0]}
                                           : v[18:0];
            {e_ctl.r1, e_ctl.r0} = {len[j] == 18, !vcc};
         end
         outs();
      end
      print_verdict();
   end
endmodule
bind tuner_pll_control tuner_pll_control_assertions i_chk (.*);
`default_nettype wire
